// ---- shared/timer8_pkg.sv ----
// Shared definitions for the single-compare 8-bit timer/counter.
// Assumes the CPU side and the timer sit on one system clock.
package timer8_pkg;

  // Count extremes
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;

  // Waveform mode codes
  localparam logic [1:0] WAVE_NORMAL = 2'h0;
  localparam logic [1:0] WAVE_PHASE_PWM = 2'h1;
  localparam logic [1:0] WAVE_CTC = 2'h2;
  localparam logic [1:0] WAVE_FAST_PWM = 2'h3;

  // Clock select codes
  localparam logic [2:0] CLK_NONE = 3'h0;
  localparam logic [2:0] CLK_DIV1 = 3'h1;
  localparam logic [2:0] CLK_DIV8 = 3'h2;
  localparam logic [2:0] CLK_DIV64 = 3'h3;
  localparam logic [2:0] CLK_DIV256 = 3'h4;
  localparam logic [2:0] CLK_DIV1024 = 3'h5;
  localparam logic [2:0] CLK_EXT_FALL = 3'h6;
  localparam logic [2:0] CLK_EXT_RISE = 3'h7;

  // Compare output mode codes
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_TOGGLE = 2'h1;
  localparam logic [1:0] OUT_CLEAR = 2'h2;
  localparam logic [1:0] OUT_SET = 2'h3;

  // Prescaler width and tap positions (top bit index of each all-ones test)
  localparam int PRESCALE_BITS = 10;
  localparam int TAP_DIV8 = 2;
  localparam int TAP_DIV64 = 5;
  localparam int TAP_DIV256 = 7;
  localparam int TAP_DIV1024 = 9;

  // Control settings and interrupt bits
  typedef struct packed {
    logic [2:0] clock_select;
    logic [1:0] waveform_mode;
    logic [1:0] compare_output_mode;
  } timer_control_s;

  typedef struct packed {
    logic compare;
    logic overflow;
  } irq_bits_s;

  // Values after reset
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam timer_control_s CONTROL_RESET = '0;
  localparam irq_bits_s IRQ_RESET = '0;

endpackage

// ---- test/tb_timer8_single_compare.sv ----
// Self-checking bench for the single-compare 8-bit timer/counter.
// Assumes one 25 MHz system clock; the bench drives every port directly.
module tb_timer8_single_compare;
  timeunit 1ns;
  timeprecision 100ps;
  import timer8_pkg::*;

  logic clock, nrst, count_we, compare_we, control_we, force_compare, mask_we;
  logic flag_clear_we, compare_irq_ack, overflow_irq_ack, global_irq_enable, ext_count_input;
  logic [7:0] count_wdata, compare_wdata, count_value, compare_value, compare_buffer, c;
  timer_control_s control_wdata, timer_control;
  irq_bits_s mask_wdata, flag_clear_wdata, timer_irq_flags, timer_irq_mask;
  logic compare_irq, overflow_irq, compare_output, o;
  int error_cnt = 0;
  int samples_checked = 0;
  int n;
  int divs[4] = '{8, 64, 256, 1024};
  logic [1:0] oms[4] = '{OUT_TOGGLE, OUT_SET, OUT_CLEAR, OUT_NONE};

  timer8_single_compare dut_u (
    .clock(clock), .nrst(nrst), .count_we(count_we), .count_wdata(count_wdata),
    .compare_we(compare_we), .compare_wdata(compare_wdata), .control_we(control_we),
    .control_wdata(control_wdata), .force_compare(force_compare), .mask_we(mask_we),
    .mask_wdata(mask_wdata), .flag_clear_we(flag_clear_we),
    .flag_clear_wdata(flag_clear_wdata), .compare_irq_ack(compare_irq_ack),
    .overflow_irq_ack(overflow_irq_ack), .global_irq_enable(global_irq_enable),
    .ext_count_input(ext_count_input), .timer_control(timer_control),
    .count_value(count_value), .compare_value(compare_value),
    .compare_buffer(compare_buffer), .timer_irq_flags(timer_irq_flags),
    .timer_irq_mask(timer_irq_mask), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .compare_output(compare_output)
  );

  // Free-running system clock, 40 ns period
  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  // Verdict and end of run, shared by the main sequence and every wait_count timeout
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Inputs move 1 ns after the edge so no race with the design's sampling
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // One-cycle write strobes; never called twice in a row for the same strobe
  task automatic wr_ctrl(input logic [2:0] cs, input logic [1:0] wm, input logic [1:0] om);
    control_wdata = '{cs, wm, om};
    control_we = 1'h1;
    step(1);
    control_we = 1'h0;
  endtask

  task automatic wr_count(input logic [7:0] v);
    count_wdata = v;
    count_we = 1'h1;
    step(1);
    count_we = 1'h0;
  endtask

  task automatic wr_compare(input logic [7:0] v);
    compare_wdata = v;
    compare_we = 1'h1;
    step(1);
    compare_we = 1'h0;
  endtask

  task automatic force_pulse();
    force_compare = 1'h1;
    step(1);
    force_compare = 1'h0;
    step(1);
  endtask

  // Bounded wait; a miss counts and ends the run
  task automatic wait_count(input logic [7:0] v, input int lim);
    for (int i = 0; i < lim && count_value !== v; i++) begin
      step(1);
    end
    if (count_value !== v) begin
      check("count_wait", count_value, v);
      close_out();
    end
  endtask

  // Main sequence
  initial begin
    {nrst, count_we, compare_we, control_we, force_compare, mask_we} = '0;
    {flag_clear_we, compare_irq_ack, overflow_irq_ack, global_irq_enable} = '0;
    {ext_count_input, count_wdata, compare_wdata} = '0;
    control_wdata = '0;
    mask_wdata = '0;
    flag_clear_wdata = '0;
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'h1;
    step(1);
    check("count_rst", count_value, 8'h00);
    check("compare_rst", compare_value, 8'h00);
    check("control_rst", timer_control, 7'h00);
    check("irq_rst", {timer_irq_flags, timer_irq_mask}, 4'h0);
    // Match walk: equality at 5 sets the flag on the following tick
    mask_wdata = '{1'h1, 1'h0};
    mask_we = 1'h1;
    step(1);
    mask_we = 1'h0;
    check("mask", timer_irq_mask, 2'h2);
    global_irq_enable = 1'h1;
    wr_compare(8'h05);
    check("compare_direct", compare_value, 8'h05);
    wr_count(8'h04);
    wr_ctrl(CLK_DIV1, WAVE_NORMAL, OUT_TOGGLE);
    wait_count(8'h06, 10);
    check("cmp_flag", timer_irq_flags, 2'h2);
    check("out_toggle", compare_output, 1'h1);
    step(1);
    check("cmp_irq", compare_irq, 1'h1);
    check("ovf_irq_masked", overflow_irq, 1'h0);
    global_irq_enable = 1'h0;
    step(2);
    check("cmp_irq_global", compare_irq, 1'h0);
    global_irq_enable = 1'h1;
    wr_ctrl(CLK_NONE, WAVE_NORMAL, OUT_TOGGLE);
    compare_irq_ack = 1'h1;
    step(1);
    compare_irq_ack = 1'h0;
    check("cmp_ack", timer_irq_flags, 2'h0);
    c = count_value;
    step(20);
    check("halted", count_value, c);
    // Wrap from MAX sets overflow as the count reaches zero
    wr_count(8'hfd);
    wr_ctrl(CLK_DIV1, WAVE_NORMAL, OUT_NONE);
    wait_count(8'h00, 10);
    check("ovf_flag", timer_irq_flags, 2'h1);
    wr_ctrl(CLK_NONE, WAVE_NORMAL, OUT_TOGGLE);
    flag_clear_wdata = '{1'h0, 1'h1};
    flag_clear_we = 1'h1;
    step(1);
    flag_clear_we = 1'h0;
    check("ovf_clear", timer_irq_flags, 2'h0);
    // Count written equal to compare: first tick must not match
    wr_compare(8'h20);
    wr_count(8'h20);
    wr_ctrl(CLK_DIV1, WAVE_NORMAL, OUT_TOGGLE);
    o = compare_output;
    wait_count(8'h22, 10);
    check("blocked_flag", timer_irq_flags, 2'h0);
    check("blocked_out", compare_output, o);
    wr_count(8'h80);
    check("write_wins", count_value, 8'h80);
    wr_ctrl(CLK_NONE, WAVE_NORMAL, OUT_TOGGLE);
    // Let the strobe drop for a cycle before the next control write
    step(1);
    // Force in normal mode for every output mode; written mode acts at once
    c = count_value;
    for (int m = 0; m < 4; m++) begin
      wr_ctrl(CLK_NONE, WAVE_NORMAL, oms[m]);
      o = (m == 0) ? ~compare_output : (m == 1) ? 1'h1 : (m == 2) ? 1'h0 : compare_output;
      force_pulse();
      check("force_out", compare_output, o);
    end
    check("force_noflag", timer_irq_flags, 2'h0);
    check("force_nocount", count_value, c);
    wr_ctrl(CLK_NONE, WAVE_FAST_PWM, OUT_TOGGLE);
    check("mode_keep", compare_output, o);
    force_pulse();
    check("force_pwm", compare_output, o);
    // Fast PWM buffers the compare value until the MAX tick
    wr_compare(8'h40);
    check("buffer", compare_buffer, 8'h40);
    check("active_held", compare_value, 8'h20);
    wr_count(8'hfc);
    wr_ctrl(CLK_DIV1, WAVE_FAST_PWM, OUT_CLEAR);
    wait_count(8'hff, 10);
    check("active_at_max", compare_value, 8'h20);
    wait_count(8'h00, 3);
    check("active_loaded", compare_value, 8'h40);
    check("pwm_set_bottom", compare_output, 1'h1);
    // Serviced overflow clears its flag
    overflow_irq_ack = 1'h1;
    step(1);
    overflow_irq_ack = 1'h0;
    check("ovf_ack", timer_irq_flags[0], 1'h0);
    // Clear-on-match uses compare as top
    wr_ctrl(CLK_NONE, WAVE_CTC, OUT_NONE);
    wr_compare(8'h03);
    wr_count(8'h00);
    wr_ctrl(CLK_DIV1, WAVE_CTC, OUT_NONE);
    wait_count(8'h03, 10);
    // Clear lands on the match tick: the new match must win
    flag_clear_wdata = '{1'h1, 1'h0};
    flag_clear_we = 1'h1;
    step(1);
    flag_clear_we = 1'h0;
    check("ctc_clear", count_value, 8'h00);
    check("set_wins", timer_irq_flags[1], 1'h1);
    wr_ctrl(CLK_NONE, WAVE_CTC, OUT_NONE);
    flag_clear_we = 1'h1;
    step(1);
    flag_clear_we = 1'h0;
    check("cmp_write_one", timer_irq_flags[1], 1'h0);
    // Phase correct turns at MAX and counts down
    wr_count(8'hfd);
    wr_ctrl(CLK_DIV1, WAVE_PHASE_PWM, OUT_NONE);
    wait_count(8'hff, 10);
    step(1);
    check("down_count", count_value, 8'hfe);
    // Prescaled taps: measure one tick period for each divisor
    for (int k = 0; k < 4; k++) begin
      // Stop first: no stray tick during setup, and no BOTTOM write while down-counting
      wr_ctrl(CLK_NONE, WAVE_NORMAL, OUT_NONE);
      wr_count(8'h00);
      wr_ctrl(CLK_DIV8 + 3'(k), WAVE_NORMAL, OUT_NONE);
      wait_count(8'h01, divs[k] + 2);
      n = 0;
      while (count_value === 8'h01 && n < 2000) begin
        step(1);
        n++;
      end
      check("tick_period", 16'(n), 16'(divs[k]));
    end
    // External pin: four pulses give four ticks on either edge
    for (int e = 0; e < 2; e++) begin
      wr_count(8'h00);
      wr_ctrl(e ? CLK_EXT_FALL : CLK_EXT_RISE, WAVE_NORMAL, OUT_NONE);
      step(2);
      repeat (4) begin
        ext_count_input = 1'h1;
        step(3);
        ext_count_input = 1'h0;
        step(3);
      end
      step(5);
      check("ext_ticks", count_value, 8'h04);
    end
    close_out();
  end
endmodule

// ---- verilog/timer8_single_compare.sv ----
// Single-channel 8-bit timer/counter with one output compare channel.
// Assumes CPU strobes are one-cycle pulses on the system clock; only the
// external count input is asynchronous and is synchronised here.

module timer8_single_compare (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Count value access
  input wire logic count_we,
  input wire logic [7:0] count_wdata,
  // Compare value access
  input wire logic compare_we,
  input wire logic [7:0] compare_wdata,
  // Control settings and force strobe
  input wire logic control_we,
  input wire timer8_pkg::timer_control_s control_wdata,
  input wire logic force_compare,
  // Interrupt mask, flag clear, service acknowledge, global enable
  input wire logic mask_we,
  input wire timer8_pkg::irq_bits_s mask_wdata,
  input wire logic flag_clear_we,
  input wire timer8_pkg::irq_bits_s flag_clear_wdata,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  input wire logic global_irq_enable,
  // External count pin
  input wire logic ext_count_input,
  // Readback state
  output timer8_pkg::timer_control_s timer_control,
  output logic [7:0] count_value,
  output logic [7:0] compare_value,
  output logic [7:0] compare_buffer,
  output timer8_pkg::irq_bits_s timer_irq_flags,
  output timer8_pkg::irq_bits_s timer_irq_mask,
  // Interrupt requests and waveform
  output logic compare_irq,
  output logic overflow_irq,
  output logic compare_output
);
  import timer8_pkg::*;

  // PWM modes share buffering and force lockout; each has its own waveform handling
  function automatic logic is_pwm(input logic [1:0] mode);
    is_pwm = (mode == WAVE_PHASE_PWM) || (mode == WAVE_FAST_PWM);
  endfunction

  logic [PRESCALE_BITS-1:0] prescale;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic count_down;
  logic match_block;

  // Free-running prescaler; its phase is not tied to the select, so the
  // first prescaled tick may come up to one full period late
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // External pin synchroniser, then an edge-detect stage
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_count_input;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  // Timer tick selection
  wire tap8 = &prescale[TAP_DIV8:0];
  wire tap64 = &prescale[TAP_DIV64:0];
  wire tap256 = &prescale[TAP_DIV256:0];
  wire tap1024 = &prescale[TAP_DIV1024:0];
  wire ext_rise = ext_sync & ~ext_prev;
  wire ext_fall = ~ext_sync & ext_prev;
  logic timer_tick;
  always_comb begin
    unique case (timer_control.clock_select)
      CLK_NONE: timer_tick = 1'b0;
      CLK_DIV1: timer_tick = 1'b1;
      CLK_DIV8: timer_tick = tap8;
      CLK_DIV64: timer_tick = tap64;
      CLK_DIV256: timer_tick = tap256;
      CLK_DIV1024: timer_tick = tap1024;
      CLK_EXT_FALL: timer_tick = ext_fall;
      CLK_EXT_RISE: timer_tick = ext_rise;
    endcase
  end

  // Mode decode and extreme values
  wire [1:0] mode = timer_control.waveform_mode;
  wire [1:0] out_mode = timer_control.compare_output_mode;
  wire buffering = is_pwm(mode);
  wire at_max = (count_value == MAX);
  wire at_bottom = (count_value == BOTTOM);
  wire match_now = (count_value == compare_value);
  // A match seen on the tick that follows equality, unless a count write blocked it
  wire real_match = timer_tick & match_now & ~match_block;
  // TOP is MAX in PWM modes and the compare value in CTC
  wire at_top = (mode == WAVE_CTC) ? match_now : at_max;
  wire ctc_clear = timer_tick & (mode == WAVE_CTC) & at_top;
  wire pc_turn_up = count_down & at_bottom;
  wire pc_turn_down = ~count_down & at_max;
  wire buffer_load = buffering & timer_tick & at_max;
  wire forced = force_compare & ~is_pwm(mode);

  // Next count value per mode
  logic [7:0] next_count;
  logic next_down;
  always_comb begin
    next_count = count_value;
    next_down = count_down;
    if (count_we) begin
      next_count = count_wdata;
    end else if (timer_tick) begin
      if (mode == WAVE_PHASE_PWM) begin
        if (pc_turn_down) next_down = 1'b1;
        else if (pc_turn_up) next_down = 1'b0;
        next_count = next_down ? count_value - 8'h01 : count_value + 8'h01;
      end else if (ctc_clear) begin
        next_count = BOTTOM;
      end else begin
        next_count = count_value + 8'h01;
      end
    end
    if (mode != WAVE_PHASE_PWM) next_down = 1'b0;
  end

  // Overflow event: wrap from MAX, or the turn at BOTTOM in phase-correct mode
  wire ovf_event = timer_tick & ~count_we &
                   ((mode == WAVE_PHASE_PWM) ? pc_turn_up : at_max);

  // Counter, direction and match block
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count_value <= COUNT_RESET;
      count_down <= 1'b0;
      match_block <= 1'b0;
    end else begin
      count_value <= next_count;
      count_down <= next_down;
      // Block lasts until the next tick, however long the timer is stopped
      match_block <= count_we | (match_block & ~timer_tick);
    end
  end

  // Compare registers: CPU writes the buffer, active follows directly
  // when unbuffered, else only at the count extreme
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      compare_buffer <= COMPARE_RESET;
      compare_value <= COMPARE_RESET;
    end else begin
      if (compare_we) compare_buffer <= compare_wdata;
      if (compare_we && !buffering) compare_value <= compare_wdata;
      else if (buffer_load) compare_value <= compare_buffer;
    end
  end

  // Control and mask registers; output mode bits take effect at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_control <= CONTROL_RESET;
      timer_irq_mask <= IRQ_RESET;
    end else begin
      if (control_we) timer_control <= control_wdata;
      if (mask_we) timer_irq_mask <= mask_wdata;
    end
  end

  // Flags: a new event wins over a clear in the same cycle
  wire cmp_clear = compare_irq_ack | (flag_clear_we & flag_clear_wdata.compare);
  wire ovf_clear = overflow_irq_ack | (flag_clear_we & flag_clear_wdata.overflow);
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_irq_flags <= IRQ_RESET;
      compare_irq <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      timer_irq_flags.compare <= real_match | (timer_irq_flags.compare & ~cmp_clear);
      timer_irq_flags.overflow <= ovf_event | (timer_irq_flags.overflow & ~ovf_clear);
      compare_irq <= timer_irq_flags.compare & timer_irq_mask.compare
                     & global_irq_enable;
      overflow_irq <= timer_irq_flags.overflow & timer_irq_mask.overflow
                      & global_irq_enable;
    end
  end

  // Waveform generator; actions per mode and output mode
  logic next_out;
  always_comb begin
    next_out = compare_output;
    unique case (mode)
      WAVE_NORMAL, WAVE_CTC: begin
        if (real_match || forced) begin
          unique case (out_mode)
            OUT_NONE: next_out = compare_output;
            OUT_TOGGLE: next_out = ~compare_output;
            OUT_CLEAR: next_out = 1'b0;
            OUT_SET: next_out = 1'b1;
          endcase
        end
      end
      WAVE_FAST_PWM: begin
        // Match moves the output first; the BOTTOM restore wins a tie
        if (out_mode[1] && real_match) next_out = out_mode[0];
        if (out_mode[1] && timer_tick && at_max) next_out = ~out_mode[0];
      end
      WAVE_PHASE_PWM: begin
        if (out_mode[1] && real_match) begin
          next_out = count_down ? ~out_mode[0] : out_mode[0];
        end
      end
    endcase
  end

  // Output state has no mode-change reset, so it survives mode switches
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      compare_output <= 1'b0;
    end else begin
      compare_output <= next_out;
    end
  end

  // Checks on the logic above
  a_halt_no_count: assert property (@(posedge clock) disable iff (!nrst)
    (timer_control.clock_select == CLK_NONE && !count_we && !control_we)
      |=> $stable(count_value))
    else $error("counter moved with no clock source");

  a_write_has_priority: assert property (@(posedge clock) disable iff (!nrst)
    count_we |=> (count_value == $past(count_wdata)))
    else $error("count write did not take priority");

  a_match_sets_flag: assert property (@(posedge clock) disable iff (!nrst)
    (timer_tick && match_now && !match_block) |=> timer_irq_flags.compare)
    else $error("match did not set compare flag");

  a_block_suppresses: assert property (@(posedge clock) disable iff (!nrst)
    (timer_tick && match_block && !timer_irq_flags.compare)
      |=> !timer_irq_flags.compare)
    else $error("blocked match set compare flag");

  a_irq_gating: assert property (@(posedge clock) disable iff (!nrst)
    ##1 (compare_irq == ($past(timer_irq_flags.compare) && $past(timer_irq_mask.compare)
         && $past(global_irq_enable))))
    else $error("compare request not gated by enable and global flag");

  a_set_beats_clear: assert property (@(posedge clock) disable iff (!nrst)
    (real_match && cmp_clear) |=> timer_irq_flags.compare)
    else $error("clear won over a new match");

  a_normal_wrap: assert property (@(posedge clock) disable iff (!nrst)
    (timer_tick && mode == WAVE_NORMAL && at_max && !count_we)
      |=> (count_value == BOTTOM) && timer_irq_flags.overflow)
    else $error("normal mode wrap or overflow wrong");

  a_force_no_flag: assert property (@(posedge clock) disable iff (!nrst)
    (forced && !real_match && !timer_irq_flags.compare) |=> !timer_irq_flags.compare)
    else $error("force set the compare flag");

  a_buffer_holds: assert property (@(posedge clock) disable iff (!nrst)
    (buffering && !buffer_load && !control_we) |=> $stable(compare_value))
    else $error("buffered compare changed off the count extreme");

endmodule
